// File: logic/accel_fifo_port_offset_trim.sv
/*
 Readout side of a three-axis acceleration sensor: z result bytes,
 the FIFO read port and the per-axis offset trim registers.
 Assumes raw samples arrive on core_clk from the signal chain and that
 the serial front end turns host bytes into one-cycle read strobes.
*/
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module accel_fifo_port_offset_trim import trim_pkg::*; #(
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF // Words held, three per sample
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr, // Byte address of a direct access
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_burst, // Read continues a multibyte read
	output logic [7:0] reg_rdata,
	output logic [7:0] addr_ptr, // Pointer used by the next burst byte
	input wire logic raw_valid, // One-cycle strobe per new sample
	input wire accel_sample_t raw_sample,
	output accel_sample_t accel_result,
	output logic [6:0] fifo_entries,
	output logic fifo_dropped // Sample lost for lack of room
);
	// Count width is fixed by the seven-bit entries port; depths above 127
	// words would overflow it, so keep FIFO_DEPTH at or below that
	localparam int CNT_W = 7;
	localparam int PTR_W = $clog2(FIFO_DEPTH);

	// Trim registers, one pair per axis
	logic [7:0] trim_h_r [AXES];
	logic [7:0] trim_l_r [AXES];
	// Result registers after trim
	accel_sample_t result_r;
	// FIFO storage and pointers
	logic [WORD_W-1:0] mem [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [CNT_W-1:0] count_r;
	// Word being streamed and its byte phase
	logic [WORD_W-1:0] word_r;
	byte_phase_t phase_r;
	// Phase is the byte the next streamed read sends; high means a new pop
	// Pointer state for multibyte reads
	logic [7:0] ptr_r;
	logic hold_r; // Burst began at the port itself
	// A direct port read sets it; any read outside the port stream clears it
	logic [7:0] rdata_r;
	logic drop_r;

	// Adds a trim, aligned under result bits 19:4, to one axis
	function automatic logic [RESULT_W-1:0] add_trim(
		input logic [RESULT_W-1:0] raw,
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		logic [RESULT_W-1:0] aligned;
		aligned = {hi, lo, {TRIM_SHIFT{1'b0}}};
		// Wraps rather than saturates, as the chain does
		add_trim = raw + aligned;
	endfunction : add_trim

	// Turns a pointer index into the next one, wrapping at the depth
	function automatic logic [PTR_W-1:0] ptr_inc(
		input logic [PTR_W-1:0] p
	);
		if (p == PTR_W'(FIFO_DEPTH - 1)) begin
			ptr_inc = '0;
		end else begin
			ptr_inc = p + PTR_W'(1);
		end
	endfunction : ptr_inc

	// Which read this is: effective address and its kind
	logic [7:0] eff_addr;
	logic at_port;
	logic direct_pop;
	logic stream_byte;
	logic incr_zero;
	logic pop;
	logic can_push;
	logic push;

	always_comb begin
		// Burst bytes follow the internal pointer, not the bus address
		eff_addr = reg_burst ? ptr_r : reg_addr;
		at_port = reg_rd && (eff_addr == FIFO_PORT_OFS);
		direct_pop = at_port && !reg_burst;
		stream_byte = at_port && reg_burst && hold_r;
		incr_zero = at_port && reg_burst && !hold_r;
		// A new word starts on a direct read or at every third byte
		// An empty FIFO is never popped; the port then reads zero
		pop = (direct_pop || (stream_byte && phase_r == PH_HIGH)) && (count_r != '0);
		can_push = (32'(count_r) + AXES) <= FIFO_DEPTH;
		push = raw_valid && can_push;
	end

	// Trim registers: plain read/write storage
	// Writes always decode reg_addr; only reads follow the burst pointer
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < AXES; i++) begin
				trim_h_r[i] <= TRIM_RST;
				trim_l_r[i] <= TRIM_RST;
			end
		end else if (reg_wr) begin
			case (reg_addr)
				X_TRIM_H_OFS: trim_h_r[0] <= reg_wdata;
				X_TRIM_L_OFS: trim_l_r[0] <= reg_wdata;
				Y_TRIM_H_OFS: trim_h_r[1] <= reg_wdata;
				Y_TRIM_L_OFS: trim_l_r[1] <= reg_wdata;
				Z_TRIM_H_OFS: trim_h_r[2] <= reg_wdata;
				Z_TRIM_L_OFS: trim_l_r[2] <= reg_wdata;
				// Read-only and unmapped offsets ignore writes
				default: ;
			endcase
		end
	end

	// Trimmed sample, formed as the last processing step
	accel_sample_t trimmed;
	always_comb begin
		trimmed.x = add_trim(raw_sample.x, trim_h_r[0], trim_l_r[0]);
		trimmed.y = add_trim(raw_sample.y, trim_h_r[1], trim_l_r[1]);
		trimmed.z = add_trim(raw_sample.z, trim_h_r[2], trim_l_r[2]);
	end

	// Result registers update on every sample, stored or not,
	// so the live bytes keep moving while the FIFO is full
	always_ff @(posedge core_clk) begin
		if (reset) begin
			result_r <= '0;
		end else if (raw_valid) begin
			result_r <= trimmed;
		end
	end

	// FIFO write side: three words per sample, x then y then z
	// No reset on storage: a word is read only after it has been written
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= {trimmed.x, {(WORD_W-RESULT_W){1'b0}}};
			mem[ptr_inc(wr_ptr_r)] <= {trimmed.y, {(WORD_W-RESULT_W){1'b0}}};
			mem[ptr_inc(ptr_inc(wr_ptr_r))] <= {trimmed.z, {(WORD_W-RESULT_W){1'b0}}};
		end
	end

	// Write pointer advances by a whole sample
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_ptr_r <= '0;
		end else if (push) begin
			wr_ptr_r <= ptr_inc(ptr_inc(ptr_inc(wr_ptr_r)));
		end
	end

	// Read pointer advances by one word per pop
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rd_ptr_r <= '0;
		end else if (pop) begin
			rd_ptr_r <= ptr_inc(rd_ptr_r);
		end
	end

	// Entry count: push and pop in one cycle both count
	always_ff @(posedge core_clk) begin
		if (reset) begin
			count_r <= '0;
		end else begin
			count_r <= count_r + (push ? CNT_W'(AXES) : '0) - (pop ? CNT_W'(1) : '0);
		end
	end

	// Whole samples are dropped when room for three words is missing
	// A nearly full FIFO may refuse a sample although one or two words are
	// free: splitting a sample would leave the axes out of step
	always_ff @(posedge core_clk) begin
		if (reset) begin
			drop_r <= 1'b0;
		end else begin
			drop_r <= raw_valid && !can_push;
		end
	end

	// Word capture and byte phase of the port
	always_ff @(posedge core_clk) begin
		if (reset) begin
			word_r <= '0;
			phase_r <= PH_HIGH;
		end else if (direct_pop) begin
			// A direct read restarts the word, even mid-word
			word_r <= pop ? mem[rd_ptr_r] : '0;
			phase_r <= PH_MID;
		end else if (stream_byte) begin
			// Phase names the byte that this streamed read sends
			case (phase_r)
				PH_HIGH: begin
					// Three bytes sent; this byte opens a fresh word
					word_r <= pop ? mem[rd_ptr_r] : '0;
					phase_r <= PH_MID;
				end
				PH_MID: phase_r <= PH_LOW;
				// The low byte closes the word; the pop waits for the next read
				PH_LOW: phase_r <= PH_HIGH;
				default: phase_r <= PH_HIGH;
			endcase
		end
	end

	// Address pointer for multibyte reads
	// Writes leave the pointer alone so a burst can resume after one
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ptr_r <= 8'h00;
			hold_r <= 1'b0;
		end else if (reg_rd) begin
			if (direct_pop) begin
				ptr_r <= FIFO_PORT_OFS;
				hold_r <= 1'b1;
			end else if (stream_byte) begin
				ptr_r <= ptr_r;
			end else begin
				// All other reads, the zero port byte included, step on
				ptr_r <= eff_addr + 8'h01;
				hold_r <= 1'b0;
			end
		end
	end

	// Read data mux, registered so data stand one cycle after the strobe
	// Every path assigns: the default comes first
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = UNMAPPED_VAL;
		case (eff_addr)
			Z_HIGH_OFS: rd_mux = result_r.z[19:12];
			Z_MID_OFS: rd_mux = result_r.z[11:4];
			Z_LOW_OFS: rd_mux = {result_r.z[3:0], 4'h0};
			FIFO_PORT_OFS: begin
				if (direct_pop) begin
					// Most significant byte leaves first
					rd_mux = pop ? mem[rd_ptr_r][23:16] : DATA_RST;
				end else if (incr_zero) begin
					// Stepped in from the low z byte: zeros, nothing popped
					rd_mux = DATA_RST;
				end else begin
					// Streamed byte: the phase names which byte of the word goes out
					case (phase_r)
						// Fourth byte of a run opens the next word at its top byte
						PH_HIGH: rd_mux = pop ? mem[rd_ptr_r][23:16] : DATA_RST;
						PH_MID: rd_mux = word_r[15:8];
						PH_LOW: rd_mux = word_r[7:0];
						default: rd_mux = DATA_RST;
					endcase
				end
			end
			X_TRIM_H_OFS: rd_mux = trim_h_r[0];
			X_TRIM_L_OFS: rd_mux = trim_l_r[0];
			Y_TRIM_H_OFS: rd_mux = trim_h_r[1];
			Y_TRIM_L_OFS: rd_mux = trim_l_r[1];
			Z_TRIM_H_OFS: rd_mux = trim_h_r[2];
			Z_TRIM_L_OFS: rd_mux = trim_l_r[2];
			default: rd_mux = UNMAPPED_VAL;
		endcase
	end

	// Read data register; zero outside read answers
	// Forcing zero between answers keeps stale bytes off the bus
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_r <= DATA_RST;
		end else if (reg_rd) begin
			rdata_r <= rd_mux;
		end else begin
			rdata_r <= DATA_RST;
		end
	end

	// Every output comes straight from a flip-flop
	assign reg_rdata = rdata_r;
	assign addr_ptr = ptr_r;
	assign accel_result = result_r;
	assign fifo_entries = count_r;
	assign fifo_dropped = drop_r;
endmodule : accel_fifo_port_offset_trim

// File: logic/trim_pkg.sv
/*
 Constants and carrier types for the acceleration readout block.
 Assumes one 8-bit register space reached by a simple strobe port.
*/
package trim_pkg;
	// Register offsets
	localparam logic [7:0] Z_HIGH_OFS = 8'h0E;
	localparam logic [7:0] Z_MID_OFS = 8'h0F;
	localparam logic [7:0] Z_LOW_OFS = 8'h10;
	localparam logic [7:0] FIFO_PORT_OFS = 8'h11;
	localparam logic [7:0] X_TRIM_H_OFS = 8'h1E;
	localparam logic [7:0] X_TRIM_L_OFS = 8'h1F;
	localparam logic [7:0] Y_TRIM_H_OFS = 8'h20;
	localparam logic [7:0] Y_TRIM_L_OFS = 8'h21;
	localparam logic [7:0] Z_TRIM_H_OFS = 8'h22;
	localparam logic [7:0] Z_TRIM_L_OFS = 8'h23;
	// Reset values
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] TRIM_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_VAL = 8'h00;
	// Field layout
	localparam int RESULT_W = 20;
	localparam int TRIM_W = 16;
	localparam int TRIM_SHIFT = 4;
	localparam int WORD_W = 24;
	localparam int AXES = 3;
	localparam int FIFO_DEPTH_DEF = 96;
	// One trimmed or raw sample of all axes
	typedef struct packed {
		logic [RESULT_W-1:0] x;
		logic [RESULT_W-1:0] y;
		logic [RESULT_W-1:0] z;
	} accel_sample_t;
	// Byte phase of the word being streamed out of the port
	typedef enum logic [1:0] {
		PH_HIGH = 2'b00,
		PH_MID = 2'b01,
		PH_LOW = 2'b10
	} byte_phase_t;
endpackage : trim_pkg

// File: dv/readout_assertions.sv
/* Port checker for the readout block.
 Bound to each instance; sees ports only. */
`timescale 1ns/10ps
module readout_checker import trim_pkg::*; #(
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_burst,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] addr_ptr,
	input wire logic raw_valid,
	input wire logic [6:0] fifo_entries,
	input wire logic fifo_dropped
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// Direct read of one offset
	sequence s_rd(logic [7:0] a);
		reg_rd && !reg_burst && reg_addr == a;
	endsequence
	// Burst byte at the given pointer
	sequence s_bu(logic [7:0] a);
		reg_rd && reg_burst && addr_ptr == a;
	endsequence
	property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	property p_pop; s_rd(FIFO_PORT_OFS) ##0 (!raw_valid && fifo_entries != 7'h00)
		|=> fifo_entries == $past(fifo_entries) - 7'h01; endproperty
	a_pop: assert property (p_pop) else $error("port read did not pop");
	property p_hold; s_rd(FIFO_PORT_OFS) |=> addr_ptr == FIFO_PORT_OFS; endproperty
	a_hold: assert property (p_hold) else $error("pointer moved");
	// Reaching the port by increment gives zero and skips on
	property p_skip; s_bu(Z_LOW_OFS) ##1 !reg_rd ##1 (s_bu(FIFO_PORT_OFS) ##0 !raw_valid)
		|=> reg_rdata == 8'h00 && addr_ptr == 8'h12 && $stable(fifo_entries); endproperty
	a_skip: assert property (p_skip) else $error("increment into port wrong");
	property p_push; raw_valid && !reg_rd && fifo_entries <= FIFO_DEPTH - 3
		|=> fifo_entries == $past(fifo_entries) + 7'h03 && !fifo_dropped; endproperty
	a_push: assert property (p_push) else $error("sample not stored");
	property p_drop; raw_valid && !reg_rd && fifo_entries > FIFO_DEPTH - 3
		|=> fifo_dropped && $stable(fifo_entries); endproperty
	a_drop: assert property (p_drop) else $error("overflow not dropped");
	property p_dcause; fifo_dropped |-> $past(raw_valid); endproperty
	a_dcause: assert property (p_dcause) else $error("drop without sample");
	property p_wrptr; reg_wr |=> $stable(addr_ptr); endproperty
	a_wrptr: assert property (p_wrptr) else $error("write moved pointer");
	property p_nib; s_rd(Z_LOW_OFS) |=> reg_rdata[3:0] == 4'h0; endproperty
	a_nib: assert property (p_nib) else $error("reserved bits set");
endmodule : readout_checker
bind accel_fifo_port_offset_trim readout_checker #(.FIFO_DEPTH(FIFO_DEPTH)) readout_checker_inst (
	.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_burst(reg_burst), .reg_rdata(reg_rdata), .addr_ptr(addr_ptr), .raw_valid(raw_valid),
	.fifo_entries(fifo_entries), .fifo_dropped(fifo_dropped));

// File: dv/host_model.sv
/* Host model: master of the register port.
 Shares core_clk with the block. */
`timescale 1ns/10ps
module host_model (
	input wire logic core_clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic reg_burst
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_burst = 1'b0;
	end
	// One write; released lines show the inverse so stale values never pass
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	// One read; data is taken only in the answer cycle
	task rd(input logic [7:0] a, input logic b, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_burst <= b;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask : rd
endmodule : host_model

// File: dv/test_accel_fifo_port_offset_trim.sv
/* Self-checking bench for the readout block.
 Host model drives the port; bench drives samples. */
`timescale 1ns/10ps
module test_accel_fifo_port_offset_trim import trim_pkg::*;;
	logic core_clk, reset, reg_wr, reg_rd, reg_burst, raw_valid, fifo_dropped;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, addr_ptr, d;
	logic [6:0] fifo_entries;
	accel_sample_t raw_sample, accel_result, s, e;
	logic [7:0] t [6] = '{8'h80, 8'h01, 8'h7F, 8'hFF, 8'h00, 8'h10}; // Trim bytes
	int n_mismatch = 0, n_checks = 0, cyc = 0;
	host_model host_model_inst (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_burst(reg_burst));
	accel_fifo_port_offset_trim #(.FIFO_DEPTH(6)) accel_fifo_port_offset_trim_inst (.core_clk(core_clk),
		.reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_burst(reg_burst), .reg_rdata(reg_rdata), .addr_ptr(addr_ptr), .raw_valid(raw_valid),
		.raw_sample(raw_sample), .accel_result(accel_result), .fifo_entries(fifo_entries),
		.fifo_dropped(fifo_dropped));
	always #2.5 core_clk = ~core_clk;
	task tally_and_finish;
		if (n_mismatch == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	// Cut a hang short
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	task chk(input string nm, input logic [59:0] v, input logic [59:0] x);
		n_checks++;
		if (v !== x) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, x, v);
		end
	endtask : chk
	task rchk(input logic [7:0] a, input logic b, input logic [7:0] x);
		host_model_inst.rd(a, b, d);
		chk("rdata", d, x);
	endtask : rchk
	// One raw sample strobe; returns after the taking edge has landed
	task push(input accel_sample_t v);
		@(posedge core_clk);
		raw_valid <= 1'b1;
		raw_sample <= v;
		@(posedge core_clk);
		raw_valid <= 1'b0;
		raw_sample <= ~v;
		#1;
	endtask : push
	// Every mapped byte and one unmapped one read zero after reset
	task t_reset;
		for (int i = 0; i < 4; i++)
			rchk(8'(8'h0E + i), 1'b0, 8'h00);
		for (int i = 0; i < 6; i++)
			rchk(8'(8'h1E + i), 1'b0, 8'h00);
		rchk(8'h30, 1'b0, 8'h00);
	endtask : t_reset
	// Signed trims shifted by four, read-only write ignored
	task t_trim;
		for (int i = 0; i < 6; i++)
			host_model_inst.wr(8'(8'h1E + i), t[i]);
		host_model_inst.wr(Z_MID_OFS, 8'hAA);
		for (int i = 0; i < 6; i++)
			rchk(8'(8'h1E + i), 1'b0, t[i]);
		s = {20'h00005, 20'hFFFFF, 20'h12345};
		e = {s.x + {16'h8001, 4'h0}, s.y + {16'h7FFF, 4'h0}, s.z + {16'h0010, 4'h0}};
		push(s);
		chk("result", accel_result, e);
		chk("entries", fifo_entries, 60'd3);
		rchk(Z_HIGH_OFS, 1'b0, e.z[19:12]);
		rchk(Z_MID_OFS, 1'b0, e.z[11:4]);
		rchk(Z_LOW_OFS, 1'b0, {e.z[3:0], 4'h0});
	endtask : t_trim
	// Fill, overflow, then pop words byte by byte
	task t_fifo;
		push(s);
		push(s);
		chk("dropped", fifo_dropped, 60'd1);
		rchk(FIFO_PORT_OFS, 1'b0, e.x[19:12]);
		chk("entries", fifo_entries, 60'd5);
		rchk(FIFO_PORT_OFS, 1'b1, e.x[11:4]);
		rchk(FIFO_PORT_OFS, 1'b1, {e.x[3:0], 4'h0});
		chk("ptr", addr_ptr, 60'h11);
		rchk(FIFO_PORT_OFS, 1'b1, e.y[19:12]);
		chk("entries", fifo_entries, 60'd4);
		rchk(FIFO_PORT_OFS, 1'b0, e.z[19:12]);
		host_model_inst.rd(Z_MID_OFS, 1'b0, d);
		host_model_inst.rd(Z_LOW_OFS, 1'b1, d);
		rchk(FIFO_PORT_OFS, 1'b1, 8'h00);
		chk("ptr", addr_ptr, 60'h12);
		chk("entries", fifo_entries, 60'd3);
	endtask : t_fifo
	// Mid-run reset clears trims, pointer and the entry count
	task t_rerst;
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		chk("entries", fifo_entries, 60'd0);
		chk("ptr", addr_ptr, 60'h00);
		rchk(X_TRIM_H_OFS, 1'b0, 8'h00);
		rchk(FIFO_PORT_OFS, 1'b0, 8'h00);
	endtask : t_rerst
	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		raw_valid = 1'b0;
		raw_sample = '0;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		t_reset;
		t_trim;
		t_fifo;
		t_rerst;
		tally_and_finish;
	end
endmodule : test_accel_fifo_port_offset_trim
